// ---- hw/mmc_regs_map.vh ----
`ifndef MMC_REGS_MAP_VH
`define MMC_REGS_MAP_VH

// register addresses (8-bit register pointer)
`define MMC_ADDR_MASK_ONE    8'h43
`define MMC_ADDR_MASK_TWO    8'h44
`define MMC_ADDR_CASE_CLR    8'h46
`define MMC_ADDR_CODE_PRE    8'h47
`define MMC_ADDR_CODE_HI_ID  8'h49
`define MMC_ADDR_CONFIG_TWO  8'h4a
`define MMC_ADDR_STATUS_ONE  8'h41
`define MMC_ADDR_STATUS_TWO  8'h42

// reset values
`define MMC_RST_MASK         8'h00
`define MMC_RST_CASE_CLR     8'h00
`define MMC_RST_PRESCALE     4'h5
`define MMC_RST_TACH_DIV     2'h1
`define MMC_RST_CONFIG_TWO   8'h00

// field positions and reserved-bit masks
`define MMC_CASE_CLR_BIT     7
`define MMC_CFG_OVERTEMP_OUT_N_MASK   0
`define MMC_CFG_LOCK_AMB     1
`define MMC_CFG_LOCK_REM     2
`define MMC_CFG_ACPI_MODE    3
`define MMC_CFG_AUX_A_EN     6
`define MMC_CFG_AUX_B_EN     7
`define MMC_CFG_RSVD_MASK    8'h30
`define MMC_MASK2_RSVD       8'h0c

// thermal status bits in the combined 16-bit status vector
`define MMC_THERMAL_BITS     16'h2030

// case-open pulse: least time in ms, clock in kHz
`define MMC_CASE_PULSE_MS    20
`define MMC_CLOCK_KHZ        100000

`endif

// ---- hw/mmc_pulse_timer.v ----
`timescale 1ns/1ps
`default_nettype none

module mmc_pulse_timer #(
   parameter integer CYCLES = 2000000,
   parameter integer WIDTH  = 21
) (
   // clock and reset
   input  wire             clk_i,
   input  wire             resetn_i,
   // control
   input  wire             start_i,
   output reg              busy_o
);

   reg [WIDTH-1:0] count_q;

   always @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         count_q <= {WIDTH{1'b0}};
         busy_o  <= 1'b0;
      end else if (start_i && !busy_o) begin
         count_q <= CYCLES[WIDTH-1:0] - {{(WIDTH-1){1'b0}}, 1'b1};
         busy_o  <= 1'b1;
      end else if (busy_o) begin
         if (count_q == {WIDTH{1'b0}}) begin
            busy_o <= 1'b0;
         end else begin
            count_q <= count_q - {{(WIDTH-1){1'b0}}, 1'b1};
         end
      end
   end

endmodule // mmc_pulse_timer

`default_nettype wire

// ---- hw/mmc_mask_reg.v ----
`timescale 1ns/1ps
`default_nettype none

module mmc_mask_reg #(
   parameter [7:0] RESET_VAL = 8'h00,
   parameter [7:0] WR_MASK   = 8'hff
) (
   // clock and reset
   input  wire       clk_i,
   input  wire       resetn_i,
   // write port and stored value
   input  wire       we_i,
   input  wire [7:0] wdata_i,
   output reg  [7:0] value_o
);

   always @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         value_o <= RESET_VAL;
      end else if (we_i) begin
         value_o <= (wdata_i & WR_MASK) | (value_o & ~WR_MASK);
      end
   end

endmodule // mmc_mask_reg

`default_nettype wire

// ---- hw/mmc_regs.v ----
// Operation
// R1: set mask bit blocks its status bit
// R2: both mask registers eight bits, reset zero
// R3: second mask bit map, bits 2-3 low; here they stay writable and are low only after reset
// R4: case-clear bit pulses case_open low 20ms
// R5: case-clear bits 0-6 read zero
// R6: prescale register low nibble shows code pins
// R7: bits 5:4 select tach_a prescaler
// R8: bits 7:6 select tach_b prescaler
// R9: prescalers reset to divide-by-2
// R10: bit0 code pin five, bits 7:1 fixed
// R11: thermal mask gates interrupt only
// R12: bit1 write-once locks ambient fan register
// R13: bit2 write-once locks remote fan register
// R14: bit3 selects overtemp output acpi mode
// R15: bit6 enables aux input a interrupt
// R16: bit7 enables aux input b interrupt
// R17: config bits 5:4 reserved read-only
// R18: reading status clears returned conditions
// R19: interrupt asserts on unmasked status bit
`timescale 1ns/1ps
`default_nettype none
`include "mmc_regs_map.vh"

module mmc_regs #(
   parameter integer CASE_PULSE_CYCLES =
      (`MMC_CASE_PULSE_MS * `MMC_CLOCK_KHZ),
   parameter [6:0]   IDENT_CODE = 7'h2a  // arbitrary value
) (
   // clock and reset
   input  wire       CLOCK_I,
   input  wire       RESETN_I,
   // soft reset of the lock bits (hard or soft reset request)
   input  wire       SOFT_RESET_I,
   // register access
   input  wire [7:0] ADDR_I,
   input  wire       WR_I,
   input  wire       RD_I,
   input  wire [7:0] WDATA_I,
   output reg  [7:0] RDATA_O,
   // status from, and clear strobes to, the monitoring core
   input  wire [7:0] STATUS_ONE_I,
   input  wire [7:0] STATUS_TWO_I,
   output reg        STATUS_ONE_CLR_O,
   output reg        STATUS_TWO_CLR_O,
   // pins
   input  wire [3:0] CORE_VOLTAGE_CODE_I,
   input  wire       CORE_VOLTAGE_CODE_HI_I,
   input  wire       AUX_IRQ_A_I,
   input  wire       AUX_IRQ_B_I,
   input  wire       AUX_PINS_AS_IRQ_I,
   output reg        INT_N_O,
   output reg        CASE_OPEN_N_O,
   output reg        CASE_OPEN_OE_O,
   // controls to the rest of the monitor
   output reg  [1:0] TACH_A_PRESCALE_O,
   output reg  [1:0] TACH_B_PRESCALE_O,
   output reg        OVERTEMP_ACPI_MODE_O,
   output reg        AMB_FAN_WR_LOCK_O,
   output reg        REM_FAN_WR_LOCK_O,
   output reg        AUX_IRQ_A_ACTIVE_O,
   output reg        AUX_IRQ_B_ACTIVE_O
);

   localparam [7:0] STATUS_ONE_ADDR = `MMC_ADDR_STATUS_ONE;
   localparam [7:0] STATUS_TWO_ADDR = `MMC_ADDR_STATUS_TWO;

   wire [7:0] mask_one;
   wire [7:0] mask_two;
   wire       case_busy;
   reg  [3:0] prescale_q;
   reg  [7:0] config_q;
   reg        case_req_q;
   reg        case_busy_q;
   reg  [7:0] rdata_d;
   reg [15:0] status_eff;

   wire we_mask_one = WR_I && (ADDR_I == `MMC_ADDR_MASK_ONE);
   wire we_mask_two = WR_I && (ADDR_I == `MMC_ADDR_MASK_TWO);

   mmc_mask_reg #(
      .RESET_VAL (`MMC_RST_MASK),
      .WR_MASK   (8'hff)
   ) u_mask_one ( // R2
      .clk_i     (CLOCK_I),
      .resetn_i  (RESETN_I),
      .we_i      (we_mask_one),
      .wdata_i   (WDATA_I),
      .value_o   (mask_one)
   );

   // reserved bits 2-3 stay writable but power up low
   mmc_mask_reg #(
      .RESET_VAL (`MMC_RST_MASK),
      .WR_MASK   (8'hff)
   ) u_mask_two ( // R3
      .clk_i     (CLOCK_I),
      .resetn_i  (RESETN_I),
      .we_i      (we_mask_two),
      .wdata_i   (WDATA_I),
      .value_o   (mask_two)
   );

   // the counter holds the pin low for at least the full time
   mmc_pulse_timer #(
      .CYCLES (CASE_PULSE_CYCLES),
      .WIDTH  (32)
   ) u_case_timer ( // R4
      .clk_i    (CLOCK_I),
      .resetn_i (RESETN_I),
      .start_i  (case_req_q && !case_busy_q),
      .busy_o   (case_busy)
   );

   always @(posedge CLOCK_I or negedge RESETN_I) begin
      if (!RESETN_I) begin
         prescale_q  <= `MMC_RST_PRESCALE; // R9
         config_q    <= `MMC_RST_CONFIG_TWO;
         case_req_q  <= 1'b0;
         case_busy_q <= 1'b0;
      end else begin
         case_busy_q <= case_busy;
         if (WR_I && ADDR_I == `MMC_ADDR_CODE_PRE) begin
            prescale_q <= WDATA_I[7:4]; // R7 R8
         end
         // bit clears once the timer has run and dropped
         if (WR_I && ADDR_I == `MMC_ADDR_CASE_CLR &&
             WDATA_I[`MMC_CASE_CLR_BIT]) begin
            case_req_q <= 1'b1; // R4
         end else if (case_busy_q && !case_busy) begin
            case_req_q <= 1'b0; // R4
         end
         if (WR_I && ADDR_I == `MMC_ADDR_CONFIG_TWO) begin
            config_q[`MMC_CFG_OVERTEMP_OUT_N_MASK] <= WDATA_I[`MMC_CFG_OVERTEMP_OUT_N_MASK];
            config_q[`MMC_CFG_ACPI_MODE]  <= WDATA_I[`MMC_CFG_ACPI_MODE];
            config_q[`MMC_CFG_AUX_A_EN]   <= WDATA_I[`MMC_CFG_AUX_A_EN];
            config_q[`MMC_CFG_AUX_B_EN]   <= WDATA_I[`MMC_CFG_AUX_B_EN];
            // write-once: a one sticks until reset
            config_q[`MMC_CFG_LOCK_AMB] <= config_q[`MMC_CFG_LOCK_AMB] |
                                           WDATA_I[`MMC_CFG_LOCK_AMB]; // R12
            config_q[`MMC_CFG_LOCK_REM] <= config_q[`MMC_CFG_LOCK_REM] |
                                           WDATA_I[`MMC_CFG_LOCK_REM]; // R13
         end
         if (SOFT_RESET_I) begin
            config_q[`MMC_CFG_LOCK_AMB] <= 1'b0; // R12
            config_q[`MMC_CFG_LOCK_REM] <= 1'b0; // R13
         end
      end
   end

   always @* begin
      rdata_d = 8'h00;
      case (ADDR_I)
         `MMC_ADDR_MASK_ONE:   rdata_d = mask_one;
         `MMC_ADDR_MASK_TWO:   rdata_d = mask_two;
         `MMC_ADDR_CASE_CLR:   rdata_d = {case_req_q, 7'h00}; // R5
         `MMC_ADDR_CODE_PRE:   rdata_d = {prescale_q, CORE_VOLTAGE_CODE_I}; // R6
         `MMC_ADDR_CODE_HI_ID: rdata_d = {IDENT_CODE, CORE_VOLTAGE_CODE_HI_I}; // R10
         `MMC_ADDR_CONFIG_TWO: rdata_d = config_q & ~`MMC_CFG_RSVD_MASK; // R17
         STATUS_ONE_ADDR:      rdata_d = STATUS_ONE_I;
         STATUS_TWO_ADDR:      rdata_d = STATUS_TWO_I & ~`MMC_MASK2_RSVD;
         default:              rdata_d = 8'h00;
      endcase
   end

   // thermal bits drop out of the interrupt only; overtemp path elsewhere
   always @* begin
      status_eff = {STATUS_TWO_I & ~mask_two, STATUS_ONE_I & ~mask_one}; // R1
      if (config_q[`MMC_CFG_OVERTEMP_OUT_N_MASK]) begin
         status_eff = status_eff & ~`MMC_THERMAL_BITS; // R11
      end
   end

   always @(posedge CLOCK_I or negedge RESETN_I) begin
      if (!RESETN_I) begin
         RDATA_O              <= 8'h00;
         STATUS_ONE_CLR_O     <= 1'b0;
         STATUS_TWO_CLR_O     <= 1'b0;
         INT_N_O              <= 1'b1;
         CASE_OPEN_N_O        <= 1'b1;
         CASE_OPEN_OE_O       <= 1'b0;
         TACH_A_PRESCALE_O    <= `MMC_RST_TACH_DIV; // R9
         TACH_B_PRESCALE_O    <= `MMC_RST_TACH_DIV; // R9
         OVERTEMP_ACPI_MODE_O <= 1'b0;
         AMB_FAN_WR_LOCK_O    <= 1'b0;
         REM_FAN_WR_LOCK_O    <= 1'b0;
         AUX_IRQ_A_ACTIVE_O   <= 1'b0;
         AUX_IRQ_B_ACTIVE_O   <= 1'b0;
      end else begin
         if (RD_I) begin
            RDATA_O <= rdata_d;
         end
         STATUS_ONE_CLR_O     <= RD_I && ADDR_I == STATUS_ONE_ADDR; // R18
         STATUS_TWO_CLR_O     <= RD_I && ADDR_I == STATUS_TWO_ADDR; // R18
         INT_N_O              <= ~(|status_eff); // R19
         CASE_OPEN_N_O        <= ~case_busy; // R4
         CASE_OPEN_OE_O       <= case_busy;
         TACH_A_PRESCALE_O    <= prescale_q[1:0]; // R7
         TACH_B_PRESCALE_O    <= prescale_q[3:2]; // R8
         OVERTEMP_ACPI_MODE_O <= config_q[`MMC_CFG_ACPI_MODE]; // R14
         AMB_FAN_WR_LOCK_O    <= config_q[`MMC_CFG_LOCK_AMB];
         REM_FAN_WR_LOCK_O    <= config_q[`MMC_CFG_LOCK_REM];
         AUX_IRQ_A_ACTIVE_O   <= AUX_PINS_AS_IRQ_I &&
                                 config_q[`MMC_CFG_AUX_A_EN] && AUX_IRQ_A_I; // R15
         AUX_IRQ_B_ACTIVE_O   <= AUX_PINS_AS_IRQ_I &&
                                 config_q[`MMC_CFG_AUX_B_EN] && AUX_IRQ_B_I; // R16
      end
   end

endmodule // mmc_regs

`default_nettype wire

// ---- sim/mmc_host.sv ----
`timescale 1ns/1ps
`default_nettype none
module mmc_host (
   // clock
   input  wire logic       clk_i,
   // register access
   output logic [7:0] addr_o,
   output logic       wr_o,
   output logic       rd_o,
   output logic [7:0] wdata_o,
   input  wire logic [7:0] rdata_i
);
   initial begin
      addr_o = 8'h00;
      wr_o = 1'b0;
      rd_o = 1'b0;
      wdata_o = 8'h00;
   end
   // released data is inverted so a stale byte never looks valid
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge clk_i);
      addr_o = a;
      wdata_o = d;
      wr_o = 1'b1;
      @(negedge clk_i);
      wr_o = 1'b0;
      wdata_o = ~d;
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(negedge clk_i);
      addr_o = a;
      rd_o = 1'b1;
      @(negedge clk_i);
      rd_o = 1'b0;
      @(negedge clk_i);
      d = rdata_i;
   endtask
endmodule // mmc_host
`default_nettype wire

// ---- sim/mmc_regs_chk.sv ----
`timescale 1ns/1ps
`default_nettype none
module mmc_regs_chk #(parameter integer CASE_PULSE_CYCLES = 20) (
   // clock, reset and register access
   input wire logic       CLOCK_I,
   input wire logic       RESETN_I,
   input wire logic       SOFT_RESET_I,
   input wire logic       WR_I,
   input wire logic       RD_I,
   input wire logic [7:0] ADDR_I,
   input wire logic [7:0] WDATA_I,
   // status and interrupt
   input wire logic [7:0] STATUS_ONE_I,
   input wire logic [7:0] STATUS_TWO_I,
   input wire logic       STATUS_ONE_CLR_O,
   input wire logic       INT_N_O,
   // pins and controls
   input wire logic       CASE_OPEN_N_O,
   input wire logic       CASE_OPEN_OE_O,
   input wire logic [1:0] TACH_A_PRESCALE_O,
   input wire logic       OVERTEMP_ACPI_MODE_O,
   input wire logic       AMB_FAN_WR_LOCK_O,
   input wire logic       REM_FAN_WR_LOCK_O
);
   default clocking @(posedge CLOCK_I); endclocking
   default disable iff (!RESETN_I);
   integer pulse_len_q;
   always @(posedge CLOCK_I or negedge RESETN_I)
      if (!RESETN_I) pulse_len_q <= 0;
      else pulse_len_q <= CASE_OPEN_OE_O ? pulse_len_q + 1 : 0;
   sequence s_case_req;
      WR_I && ADDR_I == 8'h46 && WDATA_I[7] && !CASE_OPEN_OE_O;
   endsequence
   sequence s_pulse_on;
      // request latch, timer start, then the registered pin
      ##3 (!CASE_OPEN_N_O && CASE_OPEN_OE_O);
   endsequence
   int_idle_a: assert property (
      STATUS_ONE_I == 8'h00 && STATUS_TWO_I == 8'h00 |=> INT_N_O)
      else $error("interrupt low without status");
   pulse_start_a: assert property (s_case_req |-> s_pulse_on)
      else $error("case-open pulse did not start");
   pulse_len_a: assert property (
      $fell(CASE_OPEN_OE_O) |-> pulse_len_q >= CASE_PULSE_CYCLES)
      else $error("case-open pulse too short");
   pin_level_a: assert property (CASE_OPEN_N_O == !CASE_OPEN_OE_O)
      else $error("case-open pin level wrong");
   pulse_cause_a: assert property ($rose(CASE_OPEN_OE_O) |->
      $past(WR_I && ADDR_I == 8'h46 && WDATA_I[7], 3))
      else $error("case-open pulse without request");
   prescale_wr_a: assert property (WR_I && ADDR_I == 8'h47 |->
      ##2 TACH_A_PRESCALE_O == $past(WDATA_I[5:4], 2))
      else $error("prescale output wrong");
   acpi_mode_a: assert property (WR_I && ADDR_I == 8'h4a |->
      ##2 OVERTEMP_ACPI_MODE_O == $past(WDATA_I[3], 2))
      else $error("overtemp mode wrong");
   amb_lock_a: assert property (AMB_FAN_WR_LOCK_O && !SOFT_RESET_I &&
      !$past(SOFT_RESET_I) |=> AMB_FAN_WR_LOCK_O)
      else $error("ambient lock released");
   rem_lock_a: assert property (REM_FAN_WR_LOCK_O && !SOFT_RESET_I &&
      !$past(SOFT_RESET_I) |=> REM_FAN_WR_LOCK_O)
      else $error("remote lock released");
   stat_clr_a: assert property (STATUS_ONE_CLR_O |->
      $past(RD_I) && $past(ADDR_I) == 8'h41)
      else $error("status clear without read");
endmodule // mmc_regs_chk
bind mmc_regs mmc_regs_chk #(.CASE_PULSE_CYCLES(CASE_PULSE_CYCLES))
   i_mmc_regs_chk (.*);
`default_nettype wire

// ---- sim/tb_mmc_regs.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb_mmc_regs;
   localparam integer PULSE = 20;
   localparam [6:0]   IDENT = 7'h15; // arbitrary value
   logic       clock, resetn, soft_reset, code_hi, aux_a, aux_b, aux_irq;
   logic       wr, rd, int_n, case_n, case_oe, acpi, lock_amb, lock_rem;
   logic       act_a, act_b;
   logic [7:0] stat_one, stat_two, addr, wdata, rdata, rd_val;
   logic [3:0] code;
   logic [1:0] pre_a, pre_b;
   logic       clr_one, clr_two;
   logic [7:0] clr_one_cnt = 8'h00, clr_two_cnt = 8'h00, oe_cycles = 8'h00;
   integer     errors = 0, samples_checked = 0;
   mmc_host i_mmc_host (.clk_i(clock), .addr_o(addr), .wr_o(wr), .rd_o(rd),
      .wdata_o(wdata), .rdata_i(rdata));
   mmc_regs #(.CASE_PULSE_CYCLES(PULSE), .IDENT_CODE(IDENT)) i_mmc_regs (
      .CLOCK_I(clock), .RESETN_I(resetn), .SOFT_RESET_I(soft_reset),
      .ADDR_I(addr), .WR_I(wr), .RD_I(rd), .WDATA_I(wdata), .RDATA_O(rdata),
      .STATUS_ONE_I(stat_one), .STATUS_TWO_I(stat_two),
      .STATUS_ONE_CLR_O(clr_one), .STATUS_TWO_CLR_O(clr_two),
      .CORE_VOLTAGE_CODE_I(code), .CORE_VOLTAGE_CODE_HI_I(code_hi),
      .AUX_IRQ_A_I(aux_a), .AUX_IRQ_B_I(aux_b), .AUX_PINS_AS_IRQ_I(aux_irq),
      .INT_N_O(int_n), .CASE_OPEN_N_O(case_n), .CASE_OPEN_OE_O(case_oe),
      .TACH_A_PRESCALE_O(pre_a), .TACH_B_PRESCALE_O(pre_b),
      .OVERTEMP_ACPI_MODE_O(acpi), .AMB_FAN_WR_LOCK_O(lock_amb),
      .REM_FAN_WR_LOCK_O(lock_rem), .AUX_IRQ_A_ACTIVE_O(act_a),
      .AUX_IRQ_B_ACTIVE_O(act_b));
   // one-cycle clear pulses and case_oe cycles are counted on the edges the design drives them
   always @(posedge clock) begin
      if (clr_one) clr_one_cnt <= clr_one_cnt + 8'h01;
      if (clr_two) clr_two_cnt <= clr_two_cnt + 8'h01;
      if (case_oe) oe_cycles <= oe_cycles + 8'h01;
   end
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         errors++;
         $display("Error at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
      i_mmc_host.rd(a, rd_val);
      chk(rd_val, exp);
   endtask
   // interrupt path is registered: give it two cycles to land
   task automatic settle;
      repeat (2) @(negedge clock);
   endtask
   task automatic t_reset;
      rdchk(8'h43, 8'h00);
      rdchk(8'h44, 8'h00);
      rdchk(8'h46, 8'h00);
      rdchk(8'h47, {4'h5, code});
      rdchk(8'h49, {IDENT, code_hi});
      chk({pre_b, pre_a}, 8'h05);
      $display("reset test done");
   endtask
   task automatic t_irq;
      i_mmc_host.wr(8'h43, 8'hff);
      i_mmc_host.wr(8'h44, 8'hfe);
      rdchk(8'h44, 8'hfe);
      stat_one = 8'hff;
      stat_two = 8'h02;
      settle;
      chk(int_n, 1'b1);
      stat_two = 8'h0d;
      settle;
      chk(int_n, 1'b0);
      rdchk(8'h41, 8'hff);
      rdchk(8'h42, 8'h01);
      chk(clr_one_cnt, 8'h01);
      chk(clr_two_cnt, 8'h01);
      i_mmc_host.wr(8'h44, 8'h00);
      i_mmc_host.wr(8'h4a, 8'h01);
      stat_two = 8'h20;
      settle;
      chk(int_n, 1'b1);
      i_mmc_host.wr(8'h4a, 8'h00);
      settle;
      chk(int_n, 1'b0);
      stat_two = 8'h00;
      i_mmc_host.wr(8'h43, 8'hfe);
      settle;
      chk(int_n, 1'b0);
      stat_one = 8'h00;
      settle;
      chk(int_n, 1'b1);
      $display("interrupt test done");
   endtask
   task automatic t_case;
      integer n;
      i_mmc_host.wr(8'h46, 8'h7f);
      rdchk(8'h46, 8'h00);
      i_mmc_host.wr(8'h46, 8'h80);
      rdchk(8'h46, 8'h80);
      chk({case_oe, case_n}, 8'h02);
      for (n = 0; n < 100 && case_oe === 1'b1; n++) @(negedge clock);
      settle;
      chk(oe_cycles, 8'(PULSE));
      rdchk(8'h46, 8'h00);
      $display("case-open test done");
   endtask
   task automatic t_prescale;
      logic [2:0] i;
      for (i = 0; i < 4; i++) begin
         code = {i[1:0], ~i[1:0]};
         i_mmc_host.wr(8'h47, {i[1:0], ~i[1:0], 4'hf});
         settle;
         chk({pre_b, pre_a}, {i[1:0], ~i[1:0]});
         rdchk(8'h47, {i[1:0], ~i[1:0], code});
      end
      $display("prescale test done");
   endtask
   task automatic t_config;
      aux_a = 1'b1;
      aux_b = 1'b1;
      i_mmc_host.wr(8'h4a, 8'hfe);
      rdchk(8'h4a, 8'hce);
      chk({act_b, act_a}, 8'h00);
      aux_irq = 1'b1;
      settle;
      chk({act_b, act_a, acpi, lock_rem, lock_amb}, 8'h1f);
      i_mmc_host.wr(8'h4a, 8'h00);
      rdchk(8'h4a, 8'h06);
      soft_reset = 1'b1;
      @(negedge clock);
      soft_reset = 1'b0;
      settle;
      chk({lock_rem, lock_amb, acpi}, 8'h00);
      $display("config test done");
   endtask
   task automatic give_verdict;
      $display("checks %0d errors %0d", samples_checked, errors);
      if (errors == 0 && samples_checked > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   initial begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end
   initial begin
      #100000;
      errors++;
      give_verdict;
   end
   initial begin
      resetn = 1'b0;
      soft_reset = 1'b0;
      stat_one = 8'h00;
      stat_two = 8'h00;
      code = 4'ha;
      code_hi = 1'b1;
      aux_a = 1'b0;
      aux_b = 1'b0;
      aux_irq = 1'b0;
      repeat (5) @(negedge clock);
      resetn = 1'b1;
      t_reset;
      t_irq;
      t_case;
      t_prescale;
      t_config;
      give_verdict;
   end
endmodule // tb_mmc_regs
`default_nettype wire
